// [pkg/fps_pkg.sv]
package fps_pkg;

    // ----------------------------------------------------------------
    // duty levels and ramp
    // ----------------------------------------------------------------
    localparam int unsigned DUTY_W = 8;
    localparam logic [DUTY_W-1:0] DUTY_FULL = 8'hFF;
    localparam logic [DUTY_W-1:0] RAMP_TOP = 8'hFF;
    localparam int unsigned PRE_W = 24;

    // ----------------------------------------------------------------
    // timing
    // ----------------------------------------------------------------
    localparam int unsigned CLK_HZ = 125_000_000;
    localparam int unsigned CLK_PERIOD_NS = 8;
    localparam int unsigned PWM_HZ = 30;
    localparam int unsigned RAMP_STEPS = 256;
    localparam int unsigned STEP_CLKS_DEF = CLK_HZ / (PWM_HZ * RAMP_STEPS);
    localparam int unsigned BLANK_NS = 10_000;
    localparam int unsigned BLANK_CLKS = (BLANK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned BLANK_W = 11;

    // ----------------------------------------------------------------
    // sequencer cycle counts
    // ----------------------------------------------------------------
    localparam int unsigned CNT_W = 6;
    localparam logic [CNT_W-1:0] STARTUP_LAST = 6'h1F;
    localparam logic [CNT_W-1:0] MISSING_LAST = 6'h1F;
    localparam logic [CNT_W-1:0] DIAG_LAST = 6'h02;
    localparam logic [CNT_W-1:0] CNT_ZERO = 6'h00;
    localparam logic [CNT_W-1:0] CNT_ONE = 6'h01;

    typedef enum logic [2:0] {
        ST_SHDN,
        ST_START1,
        ST_START2,
        ST_RUN,
        ST_DIAG,
        ST_RETRY,
        ST_FAULT
    } fps_state_t;

    // ----------------------------------------------------------------
    // register port
    // ----------------------------------------------------------------
    localparam int unsigned ADDR_W = 4;
    localparam logic [ADDR_W-1:0] OFS_CTRL = 4'h0;
    localparam logic [ADDR_W-1:0] OFS_STATUS = 4'h4;
    localparam int unsigned CTRL_THR_LSB = 0;
    localparam int unsigned CTRL_SOFT_SHDN = 8;
    localparam logic [DUTY_W-1:0] THR_RESET = 8'hFE;
    localparam int unsigned ST_STATE_LSB = 0;
    localparam int unsigned ST_FAULT_N = 4;
    localparam int unsigned ST_DRIVE = 5;
    localparam int unsigned ST_OVERTEMP = 6;
    localparam int unsigned ST_CNT_LSB = 8;
    localparam int unsigned ST_DUTY_LSB = 16;

    function automatic logic [DUTY_W-1:0] max_level(input logic [DUTY_W-1:0] a,
                                                      input logic [DUTY_W-1:0] b);
        max_level = (a > b) ? a : b;
    endfunction

endpackage

// [pkg/fps_ramp_if.sv]
`timescale 1ns/10ps
interface fps_ramp_if;
    logic [fps_pkg::DUTY_W-1:0] ramp;
    logic cycle_tick;
    modport src (output ramp, output cycle_tick);
    modport snk (input ramp, input cycle_tick);
endinterface

// [hw/fps_pwm_ramp.sv]
`timescale 1ns/10ps
module fps_pwm_ramp #(
    parameter int unsigned STEP_CLKS = fps_pkg::STEP_CLKS_DEF
) (
    input wire logic clock,
    input wire logic reset,
    fps_ramp_if.src rmp
);

    // ----------------------------------------------------------------
    // prescaler and ramp
    // ----------------------------------------------------------------
    localparam logic [fps_pkg::PRE_W-1:0] PRE_LAST = fps_pkg::PRE_W'(STEP_CLKS - 1);

    logic [fps_pkg::PRE_W-1:0] pre_r;
    logic [fps_pkg::PRE_W-1:0] pre_nxt;
    logic [fps_pkg::DUTY_W-1:0] ramp_r;
    logic [fps_pkg::DUTY_W-1:0] ramp_nxt;
    logic tick_r;
    logic tick_nxt;

    always_comb begin
        pre_nxt = pre_r + 1'b1;
        ramp_nxt = ramp_r;
        tick_nxt = 1'b0;
        if (pre_r == PRE_LAST) begin
            pre_nxt = '0;
            ramp_nxt = ramp_r + 1'b1;
            // one pulse per ramp wrap marks a new pwm cycle
            tick_nxt = (ramp_r == fps_pkg::RAMP_TOP);
        end
    end

    always_ff @(posedge clock) begin
        if (reset) begin
            pre_r <= '0;
            ramp_r <= '0;
            tick_r <= 1'b0;
        end else begin
            pre_r <= pre_nxt;
            ramp_r <= ramp_nxt;
            tick_r <= tick_nxt;
        end
    end

    assign rmp.ramp = ramp_r;
    assign rmp.cycle_tick = tick_r;

endmodule

// [hw/fps_supervisor.sv]
// Contract
// - after power-up or shutdown release, drive fan fully on for 32 pwm cycles
// - pulse in first start-up enters run; else retry once, then fan fault
// - normal operation loops per pwm cycle, exits only to shutdown or fault
// - clear missing-pulse count at loop start and on every detected pulse
// - shutdown request forces zero duty, fault output inactive, leaves run
// - shutdown release resumes exactly like power-up, with start-up timer
// - fault output follows over-temperature in normal operation, no latch
// - duty each cycle follows the larger of temperature and minimum levels
// - level zero gives zero duty, full-scale level gives full duty
// - missing-pulse timeout runs 3-cycle diagnostic; pulse returns to run
// - no pulse in diagnostic runs 32-cycle start-up retry; pulse returns
// - retry with no pulse leaves normal operation into fan fault
// - fan fault holds fault output low and fan output off, latched
// - fan fault clears only by shutdown request then release, or power cycle
// - sense edges become pulses; no pulses outside shutdown means fault
// - missing-pulse detector times out after 32 pwm cycles with no pulse
// - diagnostic period drives fan output continuously high
// - sense pulses right after fan output switches on are blanked
`timescale 1ns/10ps
module fps_supervisor #(
    parameter int unsigned STEP_CLKS = fps_pkg::STEP_CLKS_DEF
) (
    input wire logic clock,
    input wire logic reset,
    input wire logic [fps_pkg::DUTY_W-1:0] temp_control_level,
    input wire logic [fps_pkg::DUTY_W-1:0] min_speed_level,
    input wire logic shutdown_req,
    input wire logic sense_in,
    output logic fan_drive_out,
    output logic fault_n,
    input wire logic [fps_pkg::ADDR_W-1:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata
);

    // ----------------------------------------------------------------
    // pwm time base
    // ----------------------------------------------------------------
    fps_ramp_if rmp ();

    fps_pwm_ramp #(
        .STEP_CLKS(STEP_CLKS)
    ) u_ramp (
        .clock(clock),
        .reset(reset),
        .rmp(rmp.src)
    );

    logic tick;
    assign tick = rmp.cycle_tick;

    // ----------------------------------------------------------------
    // register port
    // ----------------------------------------------------------------
    logic [fps_pkg::DUTY_W-1:0] thr_r;
    logic [fps_pkg::DUTY_W-1:0] thr_nxt;
    logic soft_shdn_r;
    logic soft_shdn_nxt;
    logic [31:0] rdata_r;
    logic [31:0] rdata_nxt;

    fps_pkg::fps_state_t state_r;
    fps_pkg::fps_state_t state_nxt;
    logic [fps_pkg::CNT_W-1:0] cnt_r;
    logic [fps_pkg::CNT_W-1:0] cnt_nxt;
    logic [fps_pkg::DUTY_W-1:0] duty_r;
    logic [fps_pkg::DUTY_W-1:0] duty_nxt;
    logic shdn_r;
    logic shdn_nxt;
    logic overtemp_r;
    logic overtemp_nxt;
    logic drive_r;
    logic drive_nxt;
    logic fault_n_r;
    logic fault_n_nxt;

    always_comb begin
        thr_nxt = thr_r;
        soft_shdn_nxt = soft_shdn_r;
        rdata_nxt = '0;
        if (reg_wr && reg_addr == fps_pkg::OFS_CTRL) begin
            thr_nxt = reg_wdata[fps_pkg::CTRL_THR_LSB +: fps_pkg::DUTY_W];
            soft_shdn_nxt = reg_wdata[fps_pkg::CTRL_SOFT_SHDN];
        end
        if (reg_rd) begin
            unique case (reg_addr)
                fps_pkg::OFS_CTRL: begin
                    rdata_nxt[fps_pkg::CTRL_THR_LSB +: fps_pkg::DUTY_W] = thr_r;
                    rdata_nxt[fps_pkg::CTRL_SOFT_SHDN] = soft_shdn_r;
                end
                fps_pkg::OFS_STATUS: begin
                    rdata_nxt[fps_pkg::ST_STATE_LSB +: $bits(fps_pkg::fps_state_t)] = state_r;
                    rdata_nxt[fps_pkg::ST_FAULT_N] = fault_n_r;
                    rdata_nxt[fps_pkg::ST_DRIVE] = drive_r;
                    rdata_nxt[fps_pkg::ST_OVERTEMP] = overtemp_r;
                    rdata_nxt[fps_pkg::ST_CNT_LSB +: fps_pkg::CNT_W] = cnt_r;
                    rdata_nxt[fps_pkg::ST_DUTY_LSB +: fps_pkg::DUTY_W] = duty_r;
                end
                default: begin
                    rdata_nxt = '0;
                end
            endcase
        end
    end

    always_ff @(posedge clock) begin
        if (reset) begin
            thr_r <= fps_pkg::THR_RESET;
            soft_shdn_r <= 1'b0;
            rdata_r <= '0;
        end else begin
            thr_r <= thr_nxt;
            soft_shdn_r <= soft_shdn_nxt;
            rdata_r <= rdata_nxt;
        end
    end

    assign reg_rdata = rdata_r;

    // ----------------------------------------------------------------
    // sense pulse shaping and blanking
    // ----------------------------------------------------------------
    logic sense_d_r;
    logic sense_d_nxt;
    logic [fps_pkg::BLANK_W-1:0] blank_r;
    logic [fps_pkg::BLANK_W-1:0] blank_nxt;
    logic pulse_r;
    logic pulse_nxt;
    logic sense_ok;
    logic pulse_seen;

    localparam logic [fps_pkg::BLANK_W-1:0] BLANK_LOAD =
        fps_pkg::BLANK_W'(fps_pkg::BLANK_CLKS);

    always_comb begin
        sense_d_nxt = sense_in;
        blank_nxt = blank_r;
        if (drive_nxt && !drive_r) begin
            blank_nxt = BLANK_LOAD;
        end else if (blank_r != '0) begin
            blank_nxt = blank_r - 1'b1;
        end
        // rising sense edge outside the blanking window and outside shutdown
        sense_ok = sense_in && !sense_d_r && (blank_r == '0)
                   && state_r != fps_pkg::ST_SHDN;
        pulse_seen = pulse_r | sense_ok;
        // a pulse landing on the tick is used by this decision, not lost
        pulse_nxt = tick ? 1'b0 : pulse_seen;
    end

    always_ff @(posedge clock) begin
        if (reset) begin
            sense_d_r <= 1'b0;
            blank_r <= '0;
            pulse_r <= 1'b0;
        end else begin
            sense_d_r <= sense_d_nxt;
            blank_r <= blank_nxt;
            pulse_r <= pulse_nxt;
        end
    end

    // ----------------------------------------------------------------
    // per-cycle sampling of levels and requests
    // ----------------------------------------------------------------
    always_comb begin
        shdn_nxt = shdn_r;
        overtemp_nxt = overtemp_r;
        duty_nxt = duty_r;
        if (tick) begin
            shdn_nxt = shutdown_req | soft_shdn_r;
            overtemp_nxt = temp_control_level > thr_r;
            duty_nxt = fps_pkg::max_level(temp_control_level, min_speed_level);
        end
    end

    always_ff @(posedge clock) begin
        if (reset) begin
            shdn_r <= 1'b0;
            overtemp_r <= 1'b0;
            duty_r <= '0;
        end else begin
            shdn_r <= shdn_nxt;
            overtemp_r <= overtemp_nxt;
            duty_r <= duty_nxt;
        end
    end

    // ----------------------------------------------------------------
    // sequencer, one decision per pwm cycle
    // ----------------------------------------------------------------
    always_comb begin
        state_nxt = state_r;
        cnt_nxt = cnt_r;
        if (tick) begin
            cnt_nxt = cnt_r + fps_pkg::CNT_ONE;
            if (shdn_nxt && state_r != fps_pkg::ST_SHDN) begin
                state_nxt = fps_pkg::ST_SHDN;
                cnt_nxt = fps_pkg::CNT_ZERO;
            end else begin
                unique case (state_r)
                    fps_pkg::ST_SHDN: begin
                        cnt_nxt = fps_pkg::CNT_ZERO;
                        if (!shdn_nxt) begin
                            state_nxt = fps_pkg::ST_START1;
                        end
                    end
                    fps_pkg::ST_START1: begin
                        if (pulse_seen) begin
                            state_nxt = fps_pkg::ST_RUN;
                            cnt_nxt = fps_pkg::CNT_ZERO;
                        end else if (cnt_r == fps_pkg::STARTUP_LAST) begin
                            state_nxt = fps_pkg::ST_START2;
                            cnt_nxt = fps_pkg::CNT_ZERO;
                        end
                    end
                    fps_pkg::ST_START2: begin
                        if (pulse_seen) begin
                            state_nxt = fps_pkg::ST_RUN;
                            cnt_nxt = fps_pkg::CNT_ZERO;
                        end else if (cnt_r == fps_pkg::STARTUP_LAST) begin
                            state_nxt = fps_pkg::ST_FAULT;
                            cnt_nxt = fps_pkg::CNT_ZERO;
                        end
                    end
                    fps_pkg::ST_RUN: begin
                        if (pulse_seen) begin
                            cnt_nxt = fps_pkg::CNT_ZERO;
                        end else if (cnt_r == fps_pkg::MISSING_LAST) begin
                            state_nxt = fps_pkg::ST_DIAG;
                            cnt_nxt = fps_pkg::CNT_ZERO;
                        end
                    end
                    fps_pkg::ST_DIAG: begin
                        if (pulse_seen) begin
                            state_nxt = fps_pkg::ST_RUN;
                            cnt_nxt = fps_pkg::CNT_ZERO;
                        end else if (cnt_r == fps_pkg::DIAG_LAST) begin
                            state_nxt = fps_pkg::ST_RETRY;
                            cnt_nxt = fps_pkg::CNT_ZERO;
                        end
                    end
                    fps_pkg::ST_RETRY: begin
                        if (pulse_seen) begin
                            state_nxt = fps_pkg::ST_RUN;
                            cnt_nxt = fps_pkg::CNT_ZERO;
                        end else if (cnt_r == fps_pkg::STARTUP_LAST) begin
                            state_nxt = fps_pkg::ST_FAULT;
                            cnt_nxt = fps_pkg::CNT_ZERO;
                        end
                    end
                    fps_pkg::ST_FAULT: begin
                        cnt_nxt = fps_pkg::CNT_ZERO;
                    end
                    default: begin
                        state_nxt = fps_pkg::ST_SHDN;
                        cnt_nxt = fps_pkg::CNT_ZERO;
                    end
                endcase
            end
        end
    end

    always_ff @(posedge clock) begin
        if (reset) begin
            state_r <= fps_pkg::ST_START1;
            cnt_r <= fps_pkg::CNT_ZERO;
        end else begin
            state_r <= state_nxt;
            cnt_r <= cnt_nxt;
        end
    end

    // ----------------------------------------------------------------
    // fan drive and fault outputs
    // ----------------------------------------------------------------
    always_comb begin
        drive_nxt = 1'b0;
        fault_n_nxt = 1'b1;
        unique case (state_r)
            fps_pkg::ST_START1,
            fps_pkg::ST_START2,
            fps_pkg::ST_RETRY: begin
                drive_nxt = 1'b1;
                fault_n_nxt = !overtemp_r;
            end
            fps_pkg::ST_DIAG: begin
                drive_nxt = 1'b1;
                fault_n_nxt = !overtemp_r;
            end
            fps_pkg::ST_RUN: begin
                // zero level never on, full-scale level always on
                drive_nxt = (duty_r == fps_pkg::DUTY_FULL)
                            || (rmp.ramp < duty_r);
                fault_n_nxt = !overtemp_r;
            end
            fps_pkg::ST_FAULT: begin
                drive_nxt = 1'b0;
                fault_n_nxt = 1'b0;
            end
            default: begin
                drive_nxt = 1'b0;
                fault_n_nxt = 1'b1;
            end
        endcase
    end

    always_ff @(posedge clock) begin
        if (reset) begin
            drive_r <= 1'b0;
            fault_n_r <= 1'b1;
        end else begin
            drive_r <= drive_nxt;
            fault_n_r <= fault_n_nxt;
        end
    end

    assign fan_drive_out = drive_r;
    assign fault_n = fault_n_r;

endmodule

// [tb/fps_fan_model.sv]
`timescale 1ns/10ps
// ----------------------------------------------------------------
// fan and sense network
// ----------------------------------------------------------------
module fps_fan_model #(
    parameter int unsigned PERIOD = 200
) (
    input wire logic clock,
    input wire logic reset,
    input wire logic fan_drive_out,
    input wire logic fan_ok,
    output logic sense_in
);
    logic [15:0] phase_r;
    logic drive_d_r;
    always_ff @(posedge clock) begin
        drive_d_r <= fan_drive_out;
        if (reset || !fan_drive_out || phase_r == 16'(PERIOD - 1)) begin
            phase_r <= 16'h0;
        end else begin
            phase_r <= phase_r + 16'h1;
        end
        // switch-on step, then commutation dips while energised and turning
        sense_in <= !reset && ((fan_drive_out && !drive_d_r)
            || (fan_ok && fan_drive_out && phase_r >= 16'(PERIOD - 4)));
    end
endmodule

// [tb/fps_supervisor_monitor.sv]
`timescale 1ns/10ps
// ----------------------------------------------------------------
// port checks
// ----------------------------------------------------------------
module fps_supervisor_monitor #(
    parameter int unsigned STEP_CLKS = 1
) (
    input wire logic clock,
    input wire logic reset,
    input wire logic [fps_pkg::DUTY_W-1:0] temp_control_level,
    input wire logic [fps_pkg::DUTY_W-1:0] min_speed_level,
    input wire logic shutdown_req,
    input wire logic sense_in,
    input wire logic fan_drive_out,
    input wire logic fault_n,
    input wire logic [fps_pkg::ADDR_W-1:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [31:0] reg_rdata
);
    localparam int CYC = 256 * STEP_CLKS;
    localparam int SETTLE = 2 * CYC + 4;
    logic [15:0] shdn_cnt_r, shdn_cnt_nxt, dark_cnt_r, dark_cnt_nxt;
    always_comb begin
        shdn_cnt_nxt = !shutdown_req ? 16'h0 :
            (shdn_cnt_r > 16'(SETTLE)) ? shdn_cnt_r : shdn_cnt_r + 16'h1;
        dark_cnt_nxt = (shutdown_req || fault_n || fan_drive_out) ? 16'h0 :
            (dark_cnt_r > 16'(SETTLE)) ? dark_cnt_r : dark_cnt_r + 16'h1;
    end
    always_ff @(posedge clock) begin
        if (reset) begin
            shdn_cnt_r <= 16'h0;
            dark_cnt_r <= 16'h0;
        end else begin
            shdn_cnt_r <= shdn_cnt_nxt;
            dark_cnt_r <= dark_cnt_nxt;
        end
    end
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (reset);
    a_reset_quiet: assert property ($fell(reset) |-> !fan_drive_out && fault_n)
        else $error("outputs not quiet after reset");
    a_startup_full: assert property ($fell(reset) && !shutdown_req |=> fan_drive_out [*8])
        else $error("start-up drive not continuous");
    a_read_idle: assert property (!reg_rd |=> reg_rdata == 32'h0)
        else $error("read data outside read answer");
    a_unmapped_zero: assert property (reg_rd && reg_addr != fps_pkg::OFS_CTRL
        && reg_addr != fps_pkg::OFS_STATUS |=> reg_rdata == 32'h0)
        else $error("unmapped read not zero");
    a_shdn_no_drive: assert property (shdn_cnt_r > 16'(SETTLE) |-> !fan_drive_out)
        else $error("drive during shutdown");
    a_shdn_fault_off: assert property (shdn_cnt_r > 16'(SETTLE) |-> fault_n)
        else $error("fault output active during shutdown");
    a_fault_latched: assert property (dark_cnt_r > 16'(CYC) && !shutdown_req |=> !fault_n && !fan_drive_out)
        else $error("fan fault not held");
    a_release_restart: assert property ($fell(shutdown_req) |-> ##[1:SETTLE] fan_drive_out)
        else $error("no start-up after release");
endmodule
bind fps_supervisor fps_supervisor_monitor #(.STEP_CLKS(STEP_CLKS)) i_mon (.clock(clock),
    .reset(reset), .temp_control_level(temp_control_level), .min_speed_level(min_speed_level),
    .shutdown_req(shutdown_req), .sense_in(sense_in), .fan_drive_out(fan_drive_out),
    .fault_n(fault_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata));

// [tb/fan_pwm_fault_supervisor_bench.sv]
`timescale 1ns/10ps
module fan_pwm_fault_supervisor_bench;
    localparam int CYC = 256;
    logic clock = 1'b0;
    logic reset = 1'b1;
    logic [fps_pkg::DUTY_W-1:0] temp_control_level = 8'h10;
    logic [fps_pkg::DUTY_W-1:0] min_speed_level = 8'hFF;
    logic shutdown_req = 1'b0;
    logic fan_ok = 1'b1;
    logic sense_in, fan_drive_out, fault_n;
    logic [fps_pkg::ADDR_W-1:0] reg_addr = 4'h0;
    logic [31:0] reg_wdata = 32'h0;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [31:0] reg_rdata;
    logic [31:0] rnd = 32'hD3A114DC;
    int n_mismatch = 0;
    int comparisons = 0;
    always #4 clock = ~clock;
    fps_supervisor #(.STEP_CLKS(1)) i_dut (.clock(clock), .reset(reset),
        .temp_control_level(temp_control_level), .min_speed_level(min_speed_level),
        .shutdown_req(shutdown_req), .sense_in(sense_in), .fan_drive_out(fan_drive_out),
        .fault_n(fault_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata));
    fps_fan_model i_fan (.clock(clock), .reset(reset), .fan_drive_out(fan_drive_out),
        .fan_ok(fan_ok), .sense_in(sense_in));
    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] x;
        x = s ^ (s << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction
    function automatic logic [7:0] bigger(input logic [7:0] a, input logic [7:0] b);
        return (a > b) ? a : b;
    endfunction
    function automatic logic [31:0] exp_high(input logic [7:0] a, input logic [7:0] b);
        return (bigger(a, b) == 8'hFF) ? 32'h100 : {24'h0, bigger(a, b)};
    endfunction
    task automatic report_and_stop();
        $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
        if (n_mismatch == 0 && comparisons > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        comparisons++;
        if (got !== exp) begin
            n_mismatch++;
            $display("unexpected %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic reg_write(input logic [3:0] a, input logic [31:0] d);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clock);
        reg_wr <= 1'b0;
        @(posedge clock);
    endtask
    task automatic reg_read(input logic [3:0] a, output logic [31:0] d);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clock);
        reg_rd <= 1'b0;
        #1;
        d = reg_rdata;
        @(posedge clock);
    endtask
    task automatic wait_state(input logic [2:0] st, input int max_cyc, output int took);
        logic [31:0] d;
        took = 0;
        d = 32'h0;
        while (took <= max_cyc * CYC) begin
            reg_read(fps_pkg::OFS_STATUS, d);
            if (d[2:0] === st) break;
            took += 2;
        end
        check("state", {29'h0, st}, {29'h0, d[2:0]});
    endtask
    task automatic outs(input logic drv, input logic fn);
        #1;
        check("fan_drive_out", {31'h0, drv}, {31'h0, fan_drive_out});
        check("fault_n", {31'h0, fn}, {31'h0, fault_n});
    endtask
    initial begin
        repeat (90000) @(posedge clock);
        n_mismatch++;
        report_and_stop();
    end
    initial begin
        int took;
        int hi;
        logic [31:0] d;
        logic [7:0] thr;
        repeat (12) @(posedge clock);
        reset <= 1'b0;
        reg_read(fps_pkg::OFS_CTRL, d);
        check("ctrl reset", 32'h000000FE, d);
        reg_write(4'h8, 32'hFFFFFFFF);
        reg_read(4'h8, d);
        check("unmapped", 32'h0, d);
        outs(1'b1, 1'b1);
        wait_state(fps_pkg::ST_RUN, 8, took);
        $display("test startup done");
        for (int i = 0; i < 6; i++) begin
            rnd = xs(rnd);
            thr = (i == 0) ? 8'hFE : rnd[7:0];
            temp_control_level <= (i == 0) ? 8'hFF : rnd[15:8];
            reg_write(fps_pkg::OFS_CTRL, {24'h0, thr});
            repeat (3 * CYC) @(posedge clock);
            outs(1'b1, !(temp_control_level > thr));
        end
        reg_write(fps_pkg::OFS_CTRL, 32'h000000FE);
        $display("test overtemp done");
        for (int i = 0; i < 4; i++) begin
            rnd = xs(rnd);
            min_speed_level <= (i == 0) ? 8'h00 : rnd[7:0];
            temp_control_level <= (i == 0) ? 8'h00 : (i == 1) ? 8'hFF : rnd[15:8];
            repeat (2 * CYC) @(posedge clock);
            hi = 0;
            repeat (CYC) begin
                @(posedge clock);
                #1;
                if (fan_drive_out === 1'b1) hi++;
            end
            check("high clocks", exp_high(temp_control_level, min_speed_level), 32'(hi));
            reg_read(fps_pkg::OFS_STATUS, d);
            check("duty", {24'h0, bigger(temp_control_level, min_speed_level)}, {24'h0, d[23:16]});
        end
        min_speed_level <= 8'hFF;
        temp_control_level <= 8'h10;
        repeat (36 * CYC) @(posedge clock);
        wait_state(fps_pkg::ST_RUN, 0, took);
        $display("test duty done");
        min_speed_level <= 8'h00;
        temp_control_level <= 8'h00;
        wait_state(fps_pkg::ST_DIAG, 36, took);
        check("missing span", 32'h1, {31'h0, took >= 31 * CYC && took <= 34 * CYC});
        outs(1'b1, 1'b1);
        wait_state(fps_pkg::ST_RETRY, 4, took);
        outs(1'b1, 1'b1);
        wait_state(fps_pkg::ST_RUN, 6, took);
        min_speed_level <= 8'hFF;
        fan_ok <= 1'b0;
        wait_state(fps_pkg::ST_DIAG, 36, took);
        fan_ok <= 1'b1;
        wait_state(fps_pkg::ST_RUN, 3, took);
        fan_ok <= 1'b0;
        wait_state(fps_pkg::ST_DIAG, 36, took);
        wait_state(fps_pkg::ST_RETRY, 4, took);
        wait_state(fps_pkg::ST_FAULT, 34, took);
        fan_ok <= 1'b1;
        repeat (3 * CYC) @(posedge clock);
        outs(1'b0, 1'b0);
        wait_state(fps_pkg::ST_FAULT, 0, took);
        $display("test fan fault done");
        shutdown_req <= 1'b1;
        wait_state(fps_pkg::ST_SHDN, 3, took);
        repeat (2 * CYC) @(posedge clock);
        outs(1'b0, 1'b1);
        shutdown_req <= 1'b0;
        wait_state(fps_pkg::ST_START1, 3, took);
        wait_state(fps_pkg::ST_RUN, 8, took);
        fan_ok <= 1'b0;
        shutdown_req <= 1'b1;
        wait_state(fps_pkg::ST_SHDN, 3, took);
        shutdown_req <= 1'b0;
        wait_state(fps_pkg::ST_START2, 35, took);
        wait_state(fps_pkg::ST_FAULT, 35, took);
        $display("test shutdown done");
        reset <= 1'b1;
        fan_ok <= 1'b1;
        repeat (12) @(posedge clock);
        reset <= 1'b0;
        wait_state(fps_pkg::ST_START1, 0, took);
        wait_state(fps_pkg::ST_RUN, 8, took);
        $display("test power cycle done");
        reg_write(fps_pkg::OFS_CTRL, 32'h000001FE);
        wait_state(fps_pkg::ST_SHDN, 3, took);
        outs(1'b0, 1'b1);
        reg_write(fps_pkg::OFS_CTRL, 32'h000000FE);
        wait_state(fps_pkg::ST_START1, 3, took);
        $display("test soft shutdown done");
        report_and_stop();
    end
endmodule
